// *** rtl/mapper_defs.vh ***
`ifndef MAPPER_DEFS_VH
`define MAPPER_DEFS_VH
// channel kinds
`define KIND_DIM 1'b0
`define KIND_PCT 1'b1
// direction
`define DIR_TO_REG 1'b0
`define DIR_FROM_REG 1'b1
// dimming command codes on the bus side
`define CMD_UP 2'h1
`define CMD_DOWN 2'h2
`define CMD_STOP 2'h3
// action codes: none or a command
`define ACT_NONE 2'h0
// modbus function codes
`define FN_READ_HOLD 8'h03
`define FN_READ_INPUT 8'h04
`define FN_WRITE_SINGLE 8'h06
// percent register areas
`define AREA_LOW 2'h0
`define AREA_HIGH 2'h1
`define AREA_WORD 2'h2
// percent area masks and shifts
`define MASK_LOW 16'h00FF
`define MASK_HIGH 16'hFF00
`define MASK_WORD 16'hFFFF
`define SHIFT_HIGH 4'h8
`define SHIFT_NONE 4'h0
// defaults
`define DEF_REG_MAX 16'h00FF
`define DEF_BUS_MAX 8'h64
`define DEF_STOP_VAL 16'h0000
`define BITS_WORD 5'h10
`endif

// *** rtl/linear_scale.v ***
`timescale 1ns/10ps
// ----------------------------------------
// linear range conversion
// ----------------------------------------
// out = out_min + (in - in_min) * (out_max - out_min) / (in_max - in_min)
// combinational divide: short but deep; fine at channel update rates
module linear_scale #(
  parameter W = 16
) (
  input wire [W-1:0] in_val,
  input wire [W-1:0] in_min,
  input wire [W-1:0] in_max,
  input wire [W-1:0] out_min,
  input wire [W-1:0] out_max,
  output reg [W-1:0] out_val
);
  localparam XW = 2*W+3;
  reg signed [XW-1:0] in_diff;
  reg signed [XW-1:0] out_diff;
  reg signed [XW-1:0] num;
  reg signed [XW-1:0] den;
  reg signed [XW-1:0] quo;
  // no clamp: the result wraps over the whole area
  // all terms widened first so neither product nor sign can overflow
  always @* begin
    in_diff = {{(W+3){1'b0}}, in_val} - {{(W+3){1'b0}}, in_min};
    out_diff = {{(W+3){1'b0}}, out_max} - {{(W+3){1'b0}}, out_min};
    num = in_diff * out_diff;
    den = {{(W+3){1'b0}}, in_max} - {{(W+3){1'b0}}, in_min};
    if (den == {XW{1'b0}}) begin
      quo = {XW{1'b0}};
    end else begin
      quo = num / den;
    end
    out_val = out_min + quo[W-1:0];
  end
endmodule // linear_scale

// *** rtl/dimming_percent_register_mapper.v ***
`timescale 1ns/10ps
// Function
// - dim field width set by bit count
// - field offset counted from bit zero
// - each channel works in one direction
// - each dim command: none or write value
// - stop writes own value, default zero
// - writes use write single register function
// - reads use holding or input function
// - field above compare value: configured action
// - field equal compare value: configured action
// - field below compare value: configured action
// - percent maps low, high or word
// - linear map between register and bus ranges
// - no clamping to register limits
`include "mapper_defs.vh"
module dimming_percent_register_mapper #(
  parameter W = 16
) (
  input wire ref_clk,
  input wire nrst,
  input wire kind,
  input wire direction,
  input wire [4:0] bit_count,
  input wire [3:0] bit_offset,
  input wire up_set_en,
  input wire [W-1:0] up_value,
  input wire down_set_en,
  input wire [W-1:0] down_value,
  input wire stop_set_en,
  input wire [W-1:0] stop_value,
  input wire read_input_sel,
  input wire [W-1:0] compare_value,
  input wire [1:0] act_higher,
  input wire [1:0] act_match,
  input wire [1:0] act_lower,
  input wire [1:0] pct_area,
  input wire [W-1:0] reg_min,
  input wire [W-1:0] reg_max,
  input wire [7:0] bus_min,
  input wire [7:0] bus_max,
  input wire [W-1:0] reg_address,
  input wire bus_cmd_valid,
  input wire [1:0] bus_cmd,
  input wire bus_pct_valid,
  input wire [7:0] bus_pct,
  input wire poll_valid,
  input wire [W-1:0] poll_word,
  output reg wr_req,
  output reg [7:0] wr_function,
  output reg [W-1:0] wr_address,
  output reg [W-1:0] wr_data,
  output reg [W-1:0] wr_mask,
  output reg [7:0] rd_function,
  output reg [W-1:0] rd_address,
  output reg tx_cmd_valid,
  output reg [1:0] tx_cmd,
  output reg tx_pct_valid,
  output reg [7:0] tx_pct
);
  // ----------------------------------------
  // field layout
  // ----------------------------------------
  reg [W-1:0] field_mask;
  reg [W-1:0] field_val;
  reg [W-1:0] area_mask;
  reg [3:0] area_shift;
  reg [W-1:0] area_val;
  reg [W-1:0] area_min;
  reg [W-1:0] area_max;
  // mask of bit_count ones from bit zero; shifted to the offset where it is used
  always @* begin
    if (bit_count >= `BITS_WORD) begin
      field_mask = {W{1'b1}};
    end else begin
      field_mask = ({{(W-1){1'b0}}, 1'b1} << bit_count) - 1'b1;
    end
    field_val = (poll_word >> bit_offset) & field_mask;
  end
  // percent area select; low byte default
  always @* begin
    case (pct_area)
      `AREA_HIGH: begin
        area_mask = `MASK_HIGH;
        area_shift = `SHIFT_HIGH;
      end
      `AREA_WORD: begin
        area_mask = `MASK_WORD;
        area_shift = `SHIFT_NONE;
      end
      default: begin
        area_mask = `MASK_LOW;
        area_shift = `SHIFT_NONE;
      end
    endcase
    area_val = (poll_word & area_mask) >> area_shift;
    area_min = reg_min;
    area_max = reg_max;
  end
  // ----------------------------------------
  // conversions in both directions
  // ----------------------------------------
  wire [W-1:0] to_reg;
  wire [W-1:0] to_bus;
  // bus value onto register range
  linear_scale #(.W(W)) u_to_reg (
    .in_val({{(W-8){1'b0}}, bus_pct}),
    .in_min({{(W-8){1'b0}}, bus_min}),
    .in_max({{(W-8){1'b0}}, bus_max}),
    .out_min(area_min),
    .out_max(area_max),
    .out_val(to_reg)
  );
  // register area onto bus range
  linear_scale #(.W(W)) u_to_bus (
    .in_val(area_val),
    .in_min(area_min),
    .in_max(area_max),
    .out_min({{(W-8){1'b0}}, bus_min}),
    .out_max({{(W-8){1'b0}}, bus_max}),
    .out_val(to_bus)
  );
  // ----------------------------------------
  // compare and dimming command decode
  // ----------------------------------------
  reg [1:0] next_act;
  reg cmd_hit;
  reg [W-1:0] cmd_val;
  // higher, match or lower selects its own action
  always @* begin
    if (field_val > compare_value) begin
      next_act = act_higher;
    end else if (field_val == compare_value) begin
      next_act = act_match;
    end else begin
      next_act = act_lower;
    end
    case (bus_cmd)
      `CMD_UP: begin
        cmd_hit = up_set_en;
        cmd_val = up_value;
      end
      `CMD_DOWN: begin
        cmd_hit = down_set_en;
        cmd_val = down_value;
      end
      `CMD_STOP: begin
        cmd_hit = stop_set_en;
        cmd_val = stop_value;
      end
      default: begin
        cmd_hit = 1'b0;
        cmd_val = `DEF_STOP_VAL;
      end
    endcase
  end
  // ----------------------------------------
  // output registers
  // ----------------------------------------
  reg [1:0] last_act;
  reg [7:0] last_pct;
  reg have_last;
  // last result kept so repeat polls stay silent
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_req <= 1'b0;
      wr_function <= `FN_WRITE_SINGLE;
      wr_address <= {W{1'b0}};
      wr_data <= {W{1'b0}};
      wr_mask <= {W{1'b0}};
      rd_function <= `FN_READ_HOLD;
      rd_address <= {W{1'b0}};
      tx_cmd_valid <= 1'b0;
      tx_cmd <= `ACT_NONE;
      tx_pct_valid <= 1'b0;
      tx_pct <= {8{1'b0}};
      last_act <= `ACT_NONE;
      last_pct <= {8{1'b0}};
      have_last <= 1'b0;
    end else begin
      wr_req <= 1'b0;
      tx_cmd_valid <= 1'b0;
      tx_pct_valid <= 1'b0;
      wr_function <= `FN_WRITE_SINGLE;
      wr_address <= reg_address;
      rd_function <= read_input_sel ? `FN_READ_INPUT
                                    : `FN_READ_HOLD;
      rd_address <= reg_address;
      if (direction == `DIR_TO_REG) begin
        have_last <= 1'b0;
        if (kind == `KIND_DIM && bus_cmd_valid && cmd_hit) begin
          wr_req <= 1'b1;
          wr_mask <= field_mask << bit_offset;
          wr_data <= (cmd_val & field_mask) << bit_offset;
        end else if (kind == `KIND_PCT && bus_pct_valid) begin
          wr_req <= 1'b1;
          wr_mask <= area_mask;
          wr_data <= (to_reg << area_shift) & area_mask;
        end
      end else if (poll_valid) begin
        // first poll reports unless the dim action is none; later ones only on change
        if (kind == `KIND_DIM) begin
          if (!have_last || next_act != last_act) begin
            tx_cmd_valid <= (next_act != `ACT_NONE);
            tx_cmd <= next_act;
          end
          last_act <= next_act;
        end else begin
          if (!have_last || to_bus[7:0] != last_pct) begin
            tx_pct_valid <= 1'b1;
            tx_pct <= to_bus[7:0];
          end
          last_pct <= to_bus[7:0];
        end
        have_last <= 1'b1;
      end
    end
  end
endmodule // dimming_percent_register_mapper

// *** verification/mapper_assertions.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// mapper port checks
// ----------------------------------------
module mapper_assertions (
  input wire ref_clk, nrst, kind, direction, up_set_en, stop_set_en,
  input wire read_input_sel, bus_cmd_valid, bus_pct_valid, poll_valid,
  input wire wr_req, tx_cmd_valid,
  input wire [4:0] bit_count,
  input wire [3:0] bit_offset,
  input wire [1:0] bus_cmd, pct_area,
  input wire [15:0] stop_value, wr_data, wr_mask,
  input wire [7:0] wr_function, rd_function
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // field mask before the shift; 16 and above means the whole word
  wire [15:0] fw = bit_count > 5'h0F ? 16'hFFFF : ~(16'hFFFF << bit_count);
  wire dim_wr = bus_cmd_valid && !direction && !kind;
  wire stop_wr = dim_wr && bus_cmd == 2'h3 && stop_set_en;
  property p_fn; wr_function == 8'h06; endproperty
  a_fn: assert property (p_fn) else $error("write code");
  property p_rd;
    $past(nrst) |-> rd_function == ($past(read_input_sel) ? 8'h04 : 8'h03);
  endproperty
  a_rd: assert property (p_rd) else $error("read code");
  property p_stop; stop_wr |=> wr_req; endproperty
  a_stop: assert property (p_stop) else $error("stop lost");
  property p_off; dim_wr && bus_cmd == 2'h1 && !up_set_en |=> !wr_req;
  endproperty
  a_off: assert property (p_off) else $error("up wrote");
  property p_dir; bus_cmd_valid && direction |=> !wr_req; endproperty
  a_dir: assert property (p_dir) else $error("wrong way");
  property p_fld; stop_wr |=> wr_mask == $past(fw << bit_offset)
    && wr_data == $past((stop_value & fw) << bit_offset); endproperty
  a_fld: assert property (p_fld) else $error("field");
  property p_area;
    bus_pct_valid && !direction && kind && pct_area == 2'h1
      |=> wr_mask == 16'hFF00;
  endproperty
  a_area: assert property (p_area) else $error("area");
  property p_tx; tx_cmd_valid |-> $past(poll_valid && direction && !kind);
  endproperty
  a_tx: assert property (p_tx) else $error("stray send");
  c_stop: cover property (stop_wr ##1 wr_req);
  c_tx: cover property (tx_cmd_valid);
  c_pct: cover property (bus_pct_valid && kind ##1 wr_req);
endmodule // mapper_assertions
bind dimming_percent_register_mapper mapper_assertions chk (.*);

// *** verification/modbus_slave_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// far side register slave
// ----------------------------------------
module modbus_slave_model (
  input wire ref_clk, nrst, wr_req,
  input wire [7:0] wr_function,
  input wire [15:0] wr_data, wr_mask,
  output reg [15:0] held
);
  // only masked bits change, so other fields of the word survive
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) held <= 16'h0000;
    else if (wr_req && wr_function == 8'h06)
      held <= (held & ~wr_mask) | (wr_data & wr_mask);
  end
endmodule // modbus_slave_model

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
// ----------------------------------------
// mapper bench
// ----------------------------------------
module tb_top;
  reg ref_clk = 0, nrst = 0, kind = 0, direction = 0, up_set_en = 0;
  reg down_set_en = 0, stop_set_en = 0, read_input_sel = 0;
  reg bus_cmd_valid = 0, bus_pct_valid = 0, poll_valid = 0;
  reg [4:0] bit_count = 5'h10;
  reg [3:0] bit_offset = 4'h0;
  reg [1:0] act_higher = 2'h1, act_match = 2'h3, act_lower = 2'h2;
  reg [1:0] pct_area = 2'h0, bus_cmd = 2'h0;
  reg [15:0] up_value = 0, down_value = 0, stop_value = 0, poll_word = 0;
  reg [15:0] compare_value = 0, reg_min = 0, reg_max = 16'h00FF;
  reg [15:0] reg_address = 0;
  reg [7:0] bus_min = 0, bus_max = 8'h64, bus_pct = 0;
  wire wr_req, tx_cmd_valid, tx_pct_valid;
  wire [7:0] wr_function, rd_function, tx_pct;
  wire [15:0] wr_address, wr_data, wr_mask, rd_address, held;
  wire [1:0] tx_cmd;
  int errors = 0, n_compared = 0, res, last, lastp, av;
  logic [15:0] fw, v, img = 0, f;
  logic [1:0] a;
  logic en;
  dimming_percent_register_mapper dut (.*);
  modbus_slave_model slave (.*);
  always #10 ref_clk = ~ref_clk;
  // verdict, shared by the sequence and the watchdog
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, about sixty times the expected run
  initial begin
    #200000;
    errors++;
    close_out;
  end
  // inputs change on the falling edge, outputs read there too
  initial begin
    void'($urandom(32'hC98508E7));
    repeat (4) @(negedge ref_clk);
    nrst = 1;
    `CHK(wr_function, 8'h06)
    `CHK(rd_function, 8'h03)
    for (int i = 0; i < 30; i++) begin
      bit_count = $urandom_range(16, 1);
      bit_offset = $urandom;
      reg_address = $urandom;
      {up_set_en, down_set_en, stop_set_en} = $urandom;
      {up_value, down_value, stop_value} = {$urandom, $urandom};
      bus_cmd = $urandom_range(3, 1);
      bus_cmd_valid = 1;
      @(negedge ref_clk);
      bus_cmd_valid = 0;
      en = bus_cmd == 1 ? up_set_en : bus_cmd == 2 ? down_set_en : stop_set_en;
      v = bus_cmd == 1 ? up_value : bus_cmd == 2 ? down_value : stop_value;
      fw = 16'hFFFF >> (16 - bit_count);
      `CHK(wr_req, en)
      `CHK(wr_address, reg_address)
      if (en) begin
        `CHK(wr_mask, fw << bit_offset)
        `CHK(wr_data, (v & fw) << bit_offset)
        img = (img & ~(fw << bit_offset)) | ((v & fw) << bit_offset);
      end
      @(negedge ref_clk);
      `CHK(held, img)
    end
    $display("dimming writes done");
    direction = 1;
    stop_set_en = 1;
    bus_cmd = 2'h3;
    bus_cmd_valid = 1;
    @(negedge ref_clk);
    bus_cmd_valid = 0;
    `CHK(wr_req, 1'b0)
    for (int s = 0; s < 2; s++) begin
      read_input_sel = s;
      @(negedge ref_clk);
      `CHK(rd_function, s ? 8'h04 : 8'h03)
      `CHK(rd_address, reg_address)
    end
    compare_value = $urandom & fw;
    last = -1;
    for (int i = 0; i < 40; i++) begin
      if (i % 8 == 0) {act_higher, act_match, act_lower} = $urandom;
      if (i % 3 == 0) poll_word = compare_value << bit_offset;
      else if (i % 3 == 1) poll_word = $urandom;
      poll_valid = 1;
      @(negedge ref_clk);
      poll_valid = 0;
      f = (poll_word >> bit_offset) & fw;
      a = f > compare_value ? act_higher
        : f == compare_value ? act_match : act_lower;
      en = a != last && a != 2'h0;
      `CHK(tx_cmd_valid, en)
      if (en) `CHK(tx_cmd, a)
      last = a;
    end
    $display("polling done");
    direction = 0;
    kind = 1;
    for (int i = 0; i < 24; i++) begin
      pct_area = i % 3;
      if (i >= 12) begin
        reg_min = $urandom_range(15, 0);
        reg_max = reg_min + 200;
        bus_min = $urandom_range(10, 0);
        bus_max = bus_min + 100;
      end
      bus_pct = $urandom_range(255, bus_min);
      bus_pct_valid = 1;
      @(negedge ref_clk);
      bus_pct_valid = 0;
      res = reg_min + (bus_pct - bus_min) * (reg_max - reg_min)
        / (bus_max - bus_min);
      v = pct_area == 0 ? res[7:0] : pct_area == 1 ? res[7:0] << 8 : res;
      fw = pct_area == 0 ? 16'h00FF : pct_area == 1 ? 16'hFF00 : 16'hFFFF;
      `CHK(wr_req, 1'b1)
      `CHK(wr_mask, fw)
      `CHK(wr_data, v)
    end
    $display("percent writes done");
    // percent polls: odd steps repeat the word and area, so must stay silent
    direction = 1;
    lastp = -1;
    for (int i = 0; i < 24; i++) begin
      pct_area = i / 2 % 4;
      if (i % 2 == 0) poll_word = $urandom;
      poll_valid = 1;
      @(negedge ref_clk);
      poll_valid = 0;
      av = pct_area == 1 ? poll_word[15:8] : pct_area == 2 ? poll_word
        : poll_word[7:0];
      res = int'(bus_min) + (av - int'(reg_min))
        * (int'(bus_max) - int'(bus_min)) / (int'(reg_max) - int'(reg_min));
      en = res[7:0] != lastp;
      `CHK(tx_pct_valid, en)
      if (en) `CHK(tx_pct, res[7:0])
      lastp = res[7:0];
    end
    $display("percent polls done");
    close_out;
  end
endmodule // tb_top
